// [src/iocd_pkg.sv]
// constants for the channel command decoder
// assumes 24-bit command words, bit 0 is the msb as printed
//
// Contract
// - direct select pair picks channels E..H
// - unit 00 disconnect, 1x tape in, 5x out
// - 3x scan tape, 7x erase tape
// - 60/61 printers, 26/66 disc in/out
// - alert leaves buffer state untouched
// - disconnect zeroes unit address, detaches device
// - readback alert primes next parallel input
// - readback gives zeros then memory address
// - terminate output drains buffer then disconnects
// - bit 12 picks compatible or extended
// - compatible mode ignores bits 13-16
// - compatible only A-D, word/transmission end interrupts
// - extended mode everywhere, record end/zero count
// - bit 13 arms record end interrupt
// - bit 14 arms zero count interrupt
// - arms hold until channel disconnects
// - disabled system leaves armed interrupt waiting
// - bits 15-16 pick terminal function
// - bit 18 address msb, 19-23 count msbs
// - bit 9 alerts interlace once only
// - control word: opcode 02, mode 01
// - direct command decodes like ordinary command
// - terminal function encodings 00..11
// - direct channels always extended mode

package iocd_pkg;

	// ----------------------------------------
	// command word fields (msb-first numbering)
	// ----------------------------------------
	localparam int WORD_W        = 24;
	localparam logic [5:0] OPCODE_CHAN = 6'h02;
	localparam logic [5:0] OPCODE_DIR  = 6'h22;
	localparam logic [1:0] MODE_BUF    = 2'h0;
	localparam logic [1:0] MODE_IOCTL  = 2'h1;

	// ----------------------------------------
	// unit codes and buffer-control configurations
	// ----------------------------------------
	localparam logic [5:0] UNIT_DISC_IN    = 6'h16;
	localparam logic [5:0] UNIT_DISC_OUT   = 6'h36;
	localparam logic [5:0] UNIT_PRINTER_1  = 6'h30;
	localparam logic [5:0] UNIT_PRINTER_2  = 6'h31;
	localparam logic [2:0] GRP_TAPE_IN     = 3'h1;
	localparam logic [2:0] GRP_SCAN        = 3'h3;
	localparam logic [2:0] GRP_TAPE_OUT    = 3'h5;
	localparam logic [2:0] GRP_ERASE       = 3'h7;
	localparam logic [5:0] UNIT_NONE       = 6'h00;
	// bits 9..16 with unit 00: alert=050000, readback=012000, terminate=014000
	localparam logic [7:0] CFG_ALERT       = 8'ha0;
	localparam logic [7:0] CFG_READBACK    = 8'h28;
	localparam logic [7:0] CFG_TERMINATE   = 8'h30;

	// ----------------------------------------
	// terminal functions and reset values
	// ----------------------------------------
	localparam logic [1:0] TF_RECORD_DISC  = 2'h0;
	localparam logic [1:0] TF_SIGNAL_DISC  = 2'h1;
	localparam logic [1:0] TF_RECORD_PROC  = 2'h2;
	localparam logic [1:0] TF_SIGNAL_PROC  = 2'h3;
	localparam logic [5:0] RST_WC_UPPER    = 6'h00;

	typedef enum logic [2:0] {
		IOCD_IDLE     = 3'b001,
		IOCD_ACTIVE   = 3'b010,
		IOCD_DRAINING = 3'b100
	} iocd_state_e;

endpackage : iocd_pkg

// [src/iocd_unit_decode.sv]
// decodes a 6-bit unit address into peripheral selects
// assumes the code is stable while the caller samples it
`timescale 1ns/10ps

module iocd_unit_decode
	import iocd_pkg::*;
(
	// unit code in
	input  wire logic [5:0] unit_code,
	// decoded selects
	output logic            unit_disconnect,
	output logic [7:0]      tape_in,
	output logic [7:0]      tape_out,
	output logic [7:0]      tape_scan,
	output logic [7:0]      tape_erase,
	output logic [1:0]      printer,
	output logic            disc_in,
	output logic            disc_out
);
	logic [7:0] drive_onehot;

	always_comb begin
		drive_onehot = 8'h01 << unit_code[2:0];
		unit_disconnect = (unit_code == UNIT_NONE);
		tape_in  = (unit_code[5:3] == GRP_TAPE_IN)  ? drive_onehot : 8'h00;
		tape_out = (unit_code[5:3] == GRP_TAPE_OUT) ? drive_onehot : 8'h00;
		tape_scan  = (unit_code[5:3] == GRP_SCAN)  ? drive_onehot : 8'h00;
		tape_erase = (unit_code[5:3] == GRP_ERASE) ? drive_onehot : 8'h00;
		printer  = {unit_code == UNIT_PRINTER_2, unit_code == UNIT_PRINTER_1};
		disc_in  = (unit_code == UNIT_DISC_IN);
		disc_out = (unit_code == UNIT_DISC_OUT);
	end

endmodule : iocd_unit_decode

// [src/iocd_top.sv]
// channel command decoder: one command word per cmd_valid pulse
// assumes the processor holds program order; buffer and data paths live outside
`timescale 1ns/10ps

module iocd_top
	import iocd_pkg::*;
(
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// command from the processor
	input  wire logic              cmd_valid,
	input  wire logic [WORD_W-1:0] cmd_word,
	input  wire logic              parallel_input,
	input  wire logic              interrupt_system_enable,
	// channel-side events
	input  wire logic              buffer_empty,
	input  wire logic              record_end_event,
	input  wire logic              zero_count_event,
	input  wire logic              word_end_event,
	input  wire logic              transmission_end_event,
	input  wire logic [14:0]       channel_mem_addr,
	input  wire logic [2:0]        readback_channel,
	// channel selection and command class
	output logic [2:0]             channel,
	output logic                   direct_access_channel,
	output logic                   channel_alert,
	output logic                   channel_disconnect,
	output logic                   address_readback_alert,
	output logic                   terminate_output,
	// unit selects
	output logic [5:0]             unit_address,
	output logic                   peripheral_detach,
	output logic [7:0]             tape_in,
	output logic [7:0]             tape_out,
	output logic [7:0]             tape_scan,
	output logic [7:0]             tape_erase,
	output logic [1:0]             printer,
	output logic                   disc_in,
	output logic                   disc_out,
	// io control state
	output logic                   io_control_strobe,
	output logic                   mode_reject,
	output logic                   extended_mode_select,
	output logic                   record_end_arm,
	output logic                   zero_count_arm,
	output logic [1:0]             terminal_function_select,
	output logic                   address_upper,
	output logic [4:0]             word_count_upper,
	output logic                   interlace_alert,
	// readback and interrupts
	output logic [WORD_W-1:0]      readback_word,
	output logic                   readback_valid,
	output logic                   record_end_interrupt,
	output logic                   zero_count_interrupt,
	output logic                   word_end_interrupt,
	output logic                   transmission_end_interrupt
);
	// ----------------------------------------
	// field extraction (bit 0 = msb)
	// ----------------------------------------
	logic       f_is_dir;
	logic       f_is_cmd;
	logic [1:0] f_mode;
	logic [2:0] f_chan;
	logic [5:0] f_unit;
	logic [7:0] f_cfg;
	logic       f_ext;
	logic       next_ext;
	logic       unit_disc;
	logic [7:0] d_tin, d_tout, d_scan, d_erase;
	logic [1:0] d_prn;
	logic       d_din, d_dout;
	logic       buf_cmd;
	logic       ioc_cmd;
	logic       spec_cmd;
	logic       rb_primed;
	logic [2:0] rb_chan;
	logic [7:0] ilace_seen;
	iocd_state_e state;

	always_comb begin
		f_is_cmd = (cmd_word[20:15] == OPCODE_CHAN) || (cmd_word[20:15] == OPCODE_DIR);
		f_is_dir = cmd_word[20];
		f_mode   = cmd_word[13:12];
		f_chan   = {f_is_dir, cmd_word[22], cmd_word[6]};
		f_unit   = cmd_word[5:0];
		f_cfg    = cmd_word[14:7];
		f_ext    = f_is_dir | cmd_word[11];
		next_ext = f_ext;
		buf_cmd  = cmd_valid && f_is_cmd && (f_mode == MODE_BUF);
		// special words carry the control-mode code, so they win over it
		spec_cmd = cmd_valid && f_is_cmd && unit_disc
			&& (f_cfg == CFG_ALERT || f_cfg == CFG_READBACK || f_cfg == CFG_TERMINATE);
		ioc_cmd  = cmd_valid && f_is_cmd && (f_mode == MODE_IOCTL) && !spec_cmd;
	end

	iocd_unit_decode u_unit (
		.unit_code       (f_unit),
		.unit_disconnect (unit_disc),
		.tape_in         (d_tin),
		.tape_out        (d_tout),
		.tape_scan       (d_scan),
		.tape_erase      (d_erase),
		.printer         (d_prn),
		.disc_in         (d_din),
		.disc_out        (d_dout)
	);

	// ----------------------------------------
	// command class strobes
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			channel                <= 3'h0;
			direct_access_channel  <= 1'b0;
			channel_alert          <= 1'b0;
			channel_disconnect     <= 1'b0;
			address_readback_alert <= 1'b0;
			terminate_output       <= 1'b0;
			io_control_strobe      <= 1'b0;
		end else begin
			if (buf_cmd || ioc_cmd || spec_cmd) begin
				channel               <= f_chan;
				direct_access_channel <= f_is_dir;
			end
			channel_alert          <= spec_cmd && (f_cfg == CFG_ALERT);
			channel_disconnect     <= buf_cmd && unit_disc && (f_cfg == 8'h00);
			address_readback_alert <= spec_cmd && (f_cfg == CFG_READBACK);
			terminate_output       <= spec_cmd && (f_cfg == CFG_TERMINATE);
			io_control_strobe      <= ioc_cmd;
		end
	end

	// ----------------------------------------
	// unit address register and selects
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			unit_address      <= UNIT_NONE;
			peripheral_detach <= 1'b0;
			tape_in           <= 8'h00;
			tape_out          <= 8'h00;
			tape_scan         <= 8'h00;
			tape_erase        <= 8'h00;
			printer           <= 2'h0;
			disc_in           <= 1'b0;
			disc_out          <= 1'b0;
		end else begin
			peripheral_detach <= 1'b0;
			if (buf_cmd && unit_disc && f_cfg == 8'h00) begin
				unit_address      <= UNIT_NONE;
				peripheral_detach <= 1'b1;
				tape_in           <= 8'h00;
				tape_out          <= 8'h00;
				tape_scan         <= 8'h00;
				tape_erase        <= 8'h00;
				printer           <= 2'h0;
				disc_in           <= 1'b0;
				disc_out          <= 1'b0;
			end else if (buf_cmd && !unit_disc) begin
				unit_address <= f_unit;
				tape_in      <= d_tin;
				tape_out     <= d_tout;
				tape_scan    <= d_scan;
				tape_erase   <= d_erase;
				printer      <= d_prn;
				disc_in      <= d_din;
				disc_out     <= d_dout;
			end else if (state == IOCD_DRAINING && buffer_empty) begin
				unit_address      <= UNIT_NONE;
				peripheral_detach <= 1'b1;
				tape_in           <= 8'h00;
				tape_out          <= 8'h00;
				tape_scan         <= 8'h00;
				tape_erase        <= 8'h00;
				printer           <= 2'h0;
				disc_in           <= 1'b0;
				disc_out          <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// channel activity: terminate waits for the buffer to drain
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= IOCD_IDLE;
		end else begin
			case (state)
				IOCD_IDLE: begin
					if (buf_cmd && !unit_disc)
						state <= IOCD_ACTIVE;
				end
				IOCD_ACTIVE: begin
					if (buf_cmd && unit_disc && f_cfg == 8'h00)
						state <= IOCD_IDLE;
					else if (spec_cmd && f_cfg == CFG_TERMINATE)
						state <= IOCD_DRAINING;
				end
				IOCD_DRAINING: begin
					if (buffer_empty || (buf_cmd && unit_disc && f_cfg == 8'h00))
						state <= IOCD_IDLE;
				end
				default: state <= IOCD_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// io control fields; arms live for the whole operation
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reject              <= 1'b0;
			extended_mode_select     <= 1'b0;
			record_end_arm           <= 1'b0;
			zero_count_arm           <= 1'b0;
			terminal_function_select <= TF_RECORD_DISC;
			address_upper            <= 1'b0;
			word_count_upper         <= RST_WC_UPPER[4:0];
		end else begin
			mode_reject <= 1'b0;
			if (peripheral_detach) begin
				record_end_arm <= 1'b0;
				zero_count_arm <= 1'b0;
			end
			if (ioc_cmd) begin
				extended_mode_select <= next_ext;
				address_upper        <= cmd_word[5];
				word_count_upper     <= cmd_word[4:0];
				if (next_ext) begin
					record_end_arm           <= cmd_word[10];
					zero_count_arm           <= cmd_word[9];
					terminal_function_select <= cmd_word[8:7];
				end
			end
		end
	end

	// ----------------------------------------
	// interlace alert: first alerting bit per channel wins
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ilace_seen      <= 8'h00;
			interlace_alert <= 1'b0;
		end else begin
			interlace_alert <= 1'b0;
			if ((buf_cmd || ioc_cmd) && cmd_word[14] && !ilace_seen[f_chan]) begin
				ilace_seen[f_chan] <= 1'b1;
				interlace_alert    <= 1'b1;
			end
			if (buf_cmd && unit_disc && f_cfg == 8'h00)
				ilace_seen[f_chan] <= 1'b0;
		end
	end

	// ----------------------------------------
	// address readback: alert then parallel input
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rb_primed      <= 1'b0;
			rb_chan        <= 3'h0;
			readback_word  <= 24'h000000;
			readback_valid <= 1'b0;
		end else begin
			readback_valid <= 1'b0;
			if (spec_cmd && f_cfg == CFG_READBACK) begin
				rb_primed <= 1'b1;
				rb_chan   <= f_chan;
			end else if (parallel_input && rb_primed) begin
				rb_primed      <= 1'b0;
				readback_word  <= {9'h000, channel_mem_addr};
				readback_valid <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// interrupts: record end and zero count wait while the system is disabled
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			record_end_interrupt       <= 1'b0;
			zero_count_interrupt       <= 1'b0;
			word_end_interrupt         <= 1'b0;
			transmission_end_interrupt <= 1'b0;
		end else begin
			if (extended_mode_select && record_end_arm && record_end_event)
				record_end_interrupt <= 1'b1;
			else if (interrupt_system_enable && record_end_interrupt)
				record_end_interrupt <= 1'b0;
			if (extended_mode_select && zero_count_arm && zero_count_event)
				zero_count_interrupt <= 1'b1;
			else if (interrupt_system_enable && zero_count_interrupt)
				zero_count_interrupt <= 1'b0;
			word_end_interrupt <= !extended_mode_select && interrupt_system_enable
				&& word_end_event;
			transmission_end_interrupt <= !extended_mode_select && interrupt_system_enable
				&& transmission_end_event;
		end
	end

endmodule : iocd_top

// [dv/iocd_top_properties.sv]
// port-level assertions for the channel command decoder
// assumes one clock domain and the async active-low reset
`timescale 1ns/10ps

module iocd_checker
	import iocd_pkg::*;
(
	// clock and reset
	input wire logic              ref_clk,
	input wire logic              rst_n,
	// watched ports
	input wire logic              cmd_valid,
	input wire logic [WORD_W-1:0] cmd_word,
	input wire logic [14:0]       channel_mem_addr,
	input wire logic              record_end_event,
	input wire logic              interrupt_system_enable,
	input wire logic [2:0]        channel,
	input wire logic              channel_disconnect,
	input wire logic [5:0]        unit_address,
	input wire logic              extended_mode_select,
	input wire logic              record_end_arm,
	input wire logic              zero_count_arm,
	input wire logic [1:0]        terminal_function_select,
	input wire logic              address_upper,
	input wire logic [4:0]        word_count_upper,
	input wire logic [WORD_W-1:0] readback_word,
	input wire logic              readback_valid,
	input wire logic              record_end_interrupt
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	logic dir, okop, ioc, ext;
	logic [2:0] sel_chan;
	assign sel_chan = {dir, cmd_word[22], cmd_word[6]};
	assign dir  = cmd_word[20:15] == OPCODE_DIR;
	assign okop = cmd_valid && (dir || cmd_word[20:15] == OPCODE_CHAN);
	// nonzero low field so a control word never reads as a special command
	assign ioc  = okop && cmd_word[13:12] == MODE_IOCTL && cmd_word[5:0] != UNIT_NONE;
	assign ext  = ioc && (dir || cmd_word[11]);

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	property p_chan;
		okop && cmd_word[13:12] <= MODE_IOCTL |=> channel == $past(sel_chan);
	endproperty
	a_chan: assert property (p_chan) else $error("channel select wrong");
	property p_mode;
		ioc && !dir |=> extended_mode_select == $past(cmd_word[11]);
	endproperty
	a_mode: assert property (p_mode) else $error("mode bit not followed");
	property p_dirx;
		ioc && dir |=> extended_mode_select;
	endproperty
	a_dirx: assert property (p_dirx) else $error("direct channel not extended");
	property p_er;
		ext |=> record_end_arm == $past(cmd_word[10]);
	endproperty
	a_er: assert property (p_er) else $error("record end arm wrong");
	property p_zc;
		ext |=> zero_count_arm == $past(cmd_word[9]);
	endproperty
	a_zc: assert property (p_zc) else $error("zero count arm wrong");
	property p_keep;
		ioc && !dir && !cmd_word[11] |=> $stable(record_end_arm) && $stable(zero_count_arm)
			&& $stable(terminal_function_select);
	endproperty
	a_keep: assert property (p_keep) else $error("compatible word changed arms");
	property p_wc;
		ioc |=> word_count_upper == $past(cmd_word[4:0]) && address_upper == $past(cmd_word[5]);
	endproperty
	a_wc: assert property (p_wc) else $error("count or address bits wrong");
	property p_rb;
		readback_valid |-> readback_word == {9'h000, $past(channel_mem_addr)};
	endproperty
	a_rb: assert property (p_rb) else $error("readback word wrong");
	property p_disc;
		okop && cmd_word[14:7] == 8'h00 && cmd_word[5:0] == UNIT_NONE
			|=> channel_disconnect && unit_address == UNIT_NONE;
	endproperty
	a_disc: assert property (p_disc) else $error("disconnect did not clear unit");
	property p_wait;
		record_end_event && record_end_arm && !interrupt_system_enable |=> ##[0:1] record_end_interrupt;
	endproperty
	a_wait: assert property (p_wait) else $error("armed interrupt not held");
endmodule : iocd_checker

// [dv/iocd_cpu_model.sv]
// processor model issuing channel command words
// assumes the bench calls its tasks one at a time
`timescale 1ns/10ps

module iocd_cpu_model
	import iocd_pkg::*;
(
	// clock
	input wire logic              ref_clk,
	// command side of the decoder
	output logic                  cmd_valid,
	output logic [WORD_W-1:0]     cmd_word,
	output logic                  parallel_input
);
	logic primed;
	initial begin
		cmd_valid      = 1'b0;
		cmd_word       = '0;
		parallel_input = 1'b0;
		primed         = 1'b0;
	end
	// word stands one cycle, then the bus shows its inverse
	task automatic issue(input logic [WORD_W-1:0] w);
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_word  <= w;
		primed    <= w[14:7] == CFG_READBACK && w[5:0] == UNIT_NONE;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		cmd_word  <= ~w;
	endtask : issue
	task automatic pin();
		@(posedge ref_clk);
		parallel_input <= primed;
		primed         <= 1'b0;
		@(posedge ref_clk);
		parallel_input <= 1'b0;
	endtask : pin
endmodule : iocd_cpu_model

// [dv/iocd_top_tb_top.sv]
// self-checking bench for the channel command decoder
// assumes the checker and the cpu model are compiled first
`timescale 1ns/10ps

bind iocd_top iocd_checker u_chk (.ref_clk, .rst_n, .cmd_valid, .cmd_word, .channel_mem_addr,
	.record_end_event, .interrupt_system_enable, .channel, .channel_disconnect, .unit_address,
	.extended_mode_select, .record_end_arm, .zero_count_arm, .terminal_function_select,
	.address_upper, .word_count_upper, .readback_word, .readback_valid, .record_end_interrupt);

module iocd_top_tb_top;
	import iocd_pkg::*;
	logic ref_clk = 1'b0, rst_n = 1'b0, buffer_empty = 1'b1, interrupt_system_enable = 1'b0;
	logic record_end_event = 1'b0, zero_count_event = 1'b0;
	logic word_end_event = 1'b0, transmission_end_event = 1'b0;
	logic [14:0] channel_mem_addr = 15'h0000;
	logic [2:0] readback_channel = 3'h0, channel;
	logic [WORD_W-1:0] cmd_word, readback_word;
	logic cmd_valid, parallel_input, direct_access_channel, channel_alert, channel_disconnect;
	logic address_readback_alert, terminate_output, peripheral_detach, disc_in, disc_out;
	logic io_control_strobe, mode_reject, extended_mode_select, record_end_arm, zero_count_arm;
	logic address_upper, interlace_alert, readback_valid, record_end_interrupt;
	logic zero_count_interrupt, word_end_interrupt, transmission_end_interrupt;
	logic [7:0] tape_in, tape_out, tape_scan, tape_erase;
	logic [5:0] unit_address, m_unit = 6'h00;
	logic [4:0] word_count_upper;
	logic [3:0] m_ctl = 4'h0;
	logic [1:0] printer, terminal_function_select;
	wire logic [35:0] selects = {tape_in, tape_out, tape_scan, tape_erase, printer, disc_in, disc_out};
	int err_count = 0, compares = 0, i, k;
	int ilk[8] = '{default: 0};

	iocd_cpu_model u_iocd_cpu_model (.ref_clk, .cmd_valid, .cmd_word, .parallel_input);
	iocd_top u_iocd_top (.ref_clk, .rst_n, .cmd_valid, .cmd_word, .parallel_input,
		.interrupt_system_enable, .buffer_empty, .record_end_event, .zero_count_event,
		.word_end_event, .transmission_end_event, .channel_mem_addr, .readback_channel, .channel,
		.direct_access_channel, .channel_alert, .channel_disconnect, .address_readback_alert,
		.terminate_output, .unit_address, .peripheral_detach, .tape_in, .tape_out, .tape_scan,
		.tape_erase, .printer, .disc_in, .disc_out, .io_control_strobe, .mode_reject,
		.extended_mode_select, .record_end_arm, .zero_count_arm, .terminal_function_select,
		.address_upper, .word_count_upper, .interlace_alert, .readback_word, .readback_valid,
		.record_end_interrupt, .zero_count_interrupt, .word_end_interrupt, .transmission_end_interrupt);

	always #2.5 ref_clk = ~ref_clk;

	// ----------------------------------------
	// checking and stimulus helpers
	// ----------------------------------------
	task automatic results();
		if (err_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// bits 0 and 2 random, they must be ignored
	function automatic logic [WORD_W-1:0] mk(input logic [2:0] ch, input logic [7:0] cfg,
		input logic [5:0] lo);
		logic [2:0] r;
		r = 3'($urandom);
		return {r[0], ch[1], r[1], ch[2] ? OPCODE_DIR : OPCODE_CHAN, cfg, ch[0], lo};
	endfunction : mk
	function automatic logic [35:0] sel(input logic [5:0] u);
		logic [7:0] one;
		one = 8'h01 << u[2:0];
		return {(u[5:3] == GRP_TAPE_IN) ? one : 8'h00, (u[5:3] == GRP_TAPE_OUT) ? one : 8'h00,
			(u[5:3] == GRP_SCAN) ? one : 8'h00, (u[5:3] == GRP_ERASE) ? one : 8'h00,
			u == UNIT_PRINTER_2, u == UNIT_PRINTER_1, u == UNIT_DISC_IN, u == UNIT_DISC_OUT};
	endfunction : sel
	task automatic send(input logic [WORD_W-1:0] w);
		logic [7:0] cfg;
		logic [2:0] ch;
		logic       ext;
		cfg = w[14:7];
		ch  = {w[20:15] == OPCODE_DIR, w[22], w[6]};
		ext = ch[2] || w[11];
		u_iocd_cpu_model.issue(w);
		#1;
		if (!(w[20:15] inside {OPCODE_CHAN, OPCODE_DIR}) || w[13]) begin
			check("io_control_strobe", io_control_strobe, 0);
			check("unit_address", unit_address, m_unit);
			return;
		end
		check("channel", channel, ch);
		check("direct_access_channel", direct_access_channel, ch[2]);
		if (w[5:0] == UNIT_NONE && cfg == CFG_ALERT) begin
			check("channel_alert", channel_alert, 1);
			check("unit_address", unit_address, m_unit);
		end else if (w[5:0] == UNIT_NONE && cfg == CFG_READBACK)
			check("address_readback_alert", address_readback_alert, 1);
		else if (w[5:0] == UNIT_NONE && cfg == CFG_TERMINATE)
			check("terminate_output", terminate_output, 1);
		else if (w[5:0] == UNIT_NONE && cfg == 8'h00) begin
			check("channel_disconnect", channel_disconnect, 1);
			m_unit  = UNIT_NONE;
			m_ctl   = {2'h0, m_ctl[1:0]};
			ilk[ch] = 0;
		end else if (!w[12]) begin
			m_unit = w[5:0];
			check("unit_address", unit_address, m_unit);
			check("selects", selects, sel(m_unit));
		end else begin
			if (ext)
				m_ctl = w[10:7];
			check("extended", extended_mode_select, ext);
			check("io_control_strobe", io_control_strobe, 1);
			check("arms", {record_end_arm, zero_count_arm, terminal_function_select}, m_ctl);
			check("count", {address_upper, word_count_upper}, w[5:0]);
			check("interlace_alert", interlace_alert, w[14] && ilk[ch] == 0);
			if (w[14])
				ilk[ch] = 1;
		end
	endtask : send

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		logic [1:0]  seen;
		void'($urandom(32'hc520bdea));
		repeat (16) @(posedge ref_clk);
		rst_n            <= 1'b1;
		channel_mem_addr <= 15'($urandom);
		for (i = 1; i < 64; i++) begin
			r = $urandom;
			send(mk(r[2:0], {1'b0, MODE_BUF, r[7:3]}, i[5:0]));
		end
		for (i = 0; i < 8; i++)
			send(mk(i[2:0], CFG_ALERT, UNIT_NONE));
		send(mk(3'h5, CFG_READBACK, UNIT_NONE));
		u_iocd_cpu_model.pin();
		#1;
		check("readback_valid", readback_valid, 1);
		check("readback_word", readback_word, {9'h000, channel_mem_addr});
		for (i = 0; i < 8; i++)
			send(mk(i[2:0], 8'h00, UNIT_NONE));
		for (i = 0; i < 48; i++) begin
			r = $urandom;
			send(mk(r[2:0], {r[3], MODE_IOCTL, r[8:4]}, (r[14:9] == 6'h00) ? 6'h20 : r[14:9]));
		end
		send(mk(3'h2, {1'b0, 2'h2, 5'h1f}, 6'h11));
		send({3'h0, 6'h03, 15'h0a11});
		send(mk(3'h0, 8'h3c, 6'h01));
		send(mk(3'h0, 8'h00, UNIT_NONE));
		repeat (2) @(posedge ref_clk);
		#1;
		check("arms", {record_end_arm, zero_count_arm}, 0);
		send(mk(3'h1, 8'h38, 6'h01));
		@(posedge ref_clk);
		record_end_event <= 1'b1;
		zero_count_event <= 1'b1;
		@(posedge ref_clk);
		record_end_event <= 1'b0;
		zero_count_event <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		check("pending", {record_end_interrupt, zero_count_interrupt}, 2'b10);
		@(posedge ref_clk);
		interrupt_system_enable <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		check("pending", record_end_interrupt, 0);
		// compatible channel A first, then a direct channel forced extended
		for (k = 0; k < 2; k++) begin
			send(mk({k[0], 2'h0}, 8'h20, 6'h01));
			@(posedge ref_clk);
			word_end_event         <= 1'b1;
			transmission_end_event <= 1'b1;
			@(posedge ref_clk);
			word_end_event         <= 1'b0;
			transmission_end_event <= 1'b0;
			seen = 2'b00;
			repeat (3) begin
				#1;
				seen |= {word_end_interrupt, transmission_end_interrupt};
				@(posedge ref_clk);
			end
			check("compatible", seen, (k == 0) ? 2'b11 : 2'b00);
			check("mode_reject", mode_reject, 0);
		end
		buffer_empty <= 1'b0;
		send(mk(3'h0, {1'b0, MODE_BUF, 5'h00}, 6'h29));
		// channel A output ends by terminate
		send(mk(3'h0, CFG_TERMINATE, UNIT_NONE));
		repeat (4) @(posedge ref_clk);
		#1;
		check("unit_address", unit_address, 6'h29);
		@(posedge ref_clk);
		buffer_empty <= 1'b1;
		for (k = 0; k < 10 && peripheral_detach !== 1'b1; k++) begin
			@(posedge ref_clk);
			#1;
		end
		if (k == 10)
			err_count++;
		check("unit_address", unit_address, 0);
		results();
	end

	initial begin
		#100000;
		err_count++;
		results();
	end
endmodule : iocd_top_tb_top
